// ===== logic/rcsi_top.sv
// Purpose: MAC-facing pin control: reference clock, strap, receive error, interrupt, test output
// Assumes: 100 MHz core clock; crystal, management and MAC pins are asynchronous
// Notes: Rules of operation follow
// Operation
// RQ1: 25 MHz mode drives 50 MHz reference clock
// RQ2: 50 MHz mode leaves reference pin unused
// RQ3: Build variant selects power-up clock mode
// RQ4: Control register bit 7 selects clock mode
// RQ5: Receive error pin carries RMII receive error
// RQ6: Strap on receive error latched at reset release
// RQ7: Interrupt causes enabled and read at 1Bh
// RQ8: Control bit 9 sets interrupt polarity
// RQ9: Alternate wake output drives pin low
// RQ10: MAC drives transmit enable and data
// RQ11: NAND tree mode makes TXD1 an output
// RQ12: Board supplies matching crystal input clock
// RQ13: Registers reached over serial management interface
// RQ14: Interrupt held while enabled cause pending
`timescale 1ns/1ps
`include "rcsi_params.svh"
module rcsi_top #(
    parameter bit START_IN_50M = 1'b0
) (
    // Clock, reset, enable
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    // Crystal clock input
    input wire logic crystal_clock_input_i,
    // Management pins
    input wire logic mdc_i,
    input wire logic mdio_i,
    output logic mdio_o,
    output logic mdio_oe_n_o,
    // Receive error pin and strap
    input wire logic rx_err_i,
    input wire logic rx_err_pin_i,
    output logic rx_err_o,
    output logic rx_err_oe_n_o,
    // Reference clock output
    output logic ref_clk_o,
    output logic ref_clk_oe_n_o,
    // Interrupt sources and wake event
    input wire logic [`RCSI_ICS_CAUSES-1:0] int_cause_i,
    input wire logic wake_event_i,
    input wire logic wake_alt_sel_i,
    // Interrupt pin, open drain except when control bit 9 selects active high and wake_alt_sel_i is low, then driven both ways
    output logic interrupt_output_pin_o,
    output logic interrupt_output_pin_oe_n_o,
    // Transmit pins from MAC
    input wire logic tx_en_i,
    input wire logic [1:0] txd_i,
    output logic tx_en_o,
    output logic [1:0] txd_o,
    // NAND tree test
    input wire logic nand_mode_i,
    input wire logic nand_result_i,
    output logic txd1_out_o,
    output logic txd1_oe_n_o,
    // Status
    output logic wake_output_enable_strap_o,
    output logic wake_event_out_alt_n_o
);
    rcsi_reg_if reg_bus ();
    // Three-stage samplers for asynchronous inputs
    localparam int NS = 6;
    logic [NS-1:0] pin_raw;
    logic [NS-1:0] s1_ff, s2_ff, s3_ff, st_ff;
    logic [NS-1:0] nxt_st;
    assign pin_raw = {txd_i, tx_en_i, rx_err_pin_i, mdio_i, mdc_i};
    genvar gi;
    generate
        for (gi = 0; gi < NS; gi++) begin : g_sync
            always_comb begin
                nxt_st[gi] = (s2_ff[gi] == s3_ff[gi]) ? s3_ff[gi] : st_ff[gi];
            end
            always_ff @(posedge clk_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    s1_ff[gi] <= 1'b0;
                    s2_ff[gi] <= 1'b0;
                    s3_ff[gi] <= 1'b0;
                    st_ff[gi] <= 1'b0;
                end else if (ce_i) begin
                    s1_ff[gi] <= pin_raw[gi];
                    s2_ff[gi] <= s1_ff[gi];
                    s3_ff[gi] <= s2_ff[gi];
                    st_ff[gi] <= nxt_st[gi];
                end
            end
        end
    endgenerate
    logic mdc_prev_ff;
    logic mdc_rise;
    logic init_ff, nxt_init;
    // Edges are ignored until the samplers have settled after reset
    assign mdc_rise = st_ff[0] & ~mdc_prev_ff & init_ff;
    logic mdio_out, mdio_oe_n;
    rcsi_mgmt u_mgmt (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .ce_i(ce_i),
        .mdc_rise_i(mdc_rise),
        .mdio_in_i(st_ff[1]),
        .mdio_out_o(mdio_out),
        .mdio_oe_n_o(mdio_oe_n),
        .reg_port(reg_bus.eng)
    ); // RQ13

    // Registers
    logic [15:0] ctl_ff, nxt_ctl;
    logic [`RCSI_ICS_CAUSES-1:0] ien_ff, nxt_ien;
    logic [`RCSI_ICS_CAUSES-1:0] ist_ff, nxt_ist;
    logic [2:0] boot_cnt_ff, nxt_boot_cnt;
    logic strap_ff, nxt_strap;
    always_comb begin
        nxt_ctl = ctl_ff;
        nxt_ien = ien_ff;
        nxt_init = init_ff;
        nxt_boot_cnt = boot_cnt_ff;
        nxt_strap = strap_ff;
        // Strap is taken only once the three-stage sampler holds the pin level
        if (!init_ff) begin
            nxt_boot_cnt = boot_cnt_ff + 3'h1;
            if (boot_cnt_ff == `RCSI_STRAP_SETTLE) begin
                nxt_init = 1'b1;
                nxt_ctl[`RCSI_CTL_CLK50_BIT] = START_IN_50M; // RQ3
                nxt_strap = st_ff[2]; // RQ6
            end
        end
        if (reg_bus.wr_stb && reg_bus.addr == `RCSI_REG_PHY_CTL_TWO) begin
            nxt_ctl = reg_bus.wdata; // RQ4 RQ8
        end
        if (reg_bus.wr_stb && reg_bus.addr == `RCSI_REG_INT_CTL_STAT) begin
            nxt_ien = reg_bus.wdata[`RCSI_ICS_EN_LSB +: `RCSI_ICS_CAUSES]; // RQ7
        end
        // Status clears on read; a cause arriving with the read survives
        nxt_ist = ist_ff;
        if (reg_bus.rd_stb && reg_bus.addr == `RCSI_REG_INT_CTL_STAT) begin
            nxt_ist = '0;
        end
        nxt_ist = nxt_ist | int_cause_i; // RQ7
    end
    always_comb begin
        reg_bus.rdata = 16'h0000;
        if (reg_bus.addr == `RCSI_REG_PHY_CTL_TWO) begin
            reg_bus.rdata = ctl_ff;
        end else if (reg_bus.addr == `RCSI_REG_INT_CTL_STAT) begin
            reg_bus.rdata = {ien_ff, ist_ff}; // RQ7
        end
    end

    // Reference clock divider and pin outputs
    logic ref_ff, nxt_ref;
    logic [1:0] xi_prev_ff;
    logic int_act;
    logic nxt_int_n, nxt_int_oe_n;
    assign int_act = |(ist_ff & ien_ff); // RQ14
    always_comb begin
        nxt_ref = 1'b0;
        if (ctl_ff[`RCSI_CTL_CLK50_BIT] == 1'b0) begin
            nxt_ref = ~ref_ff; // RQ1
        end
        if (wake_alt_sel_i) begin
            nxt_int_n = 1'b0;
            nxt_int_oe_n = ~(wake_event_i & strap_ff); // RQ9
        end else if (ctl_ff[`RCSI_CTL_INT_POL_BIT]) begin
            nxt_int_n = int_act;
            nxt_int_oe_n = 1'b0; // RQ8
        end else begin
            nxt_int_n = 1'b0;
            nxt_int_oe_n = ~int_act; // RQ8 RQ14
        end
    end
    logic int_pin_ff, int_oe_n_ff;
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ctl_ff <= `RCSI_CTL_TWO_RESET | (16'(START_IN_50M) << `RCSI_CTL_CLK50_BIT); // RQ3
            ien_ff <= '0;
            ist_ff <= '0;
            init_ff <= 1'b0;
            boot_cnt_ff <= 3'h0;
            strap_ff <= 1'b0;
            ref_ff <= 1'b0;
            mdc_prev_ff <= 1'b0;
            xi_prev_ff <= 2'b00;
            int_pin_ff <= 1'b0;
            int_oe_n_ff <= 1'b1;
            mdio_o <= 1'b0;
            mdio_oe_n_o <= 1'b1;
            rx_err_o <= 1'b0;
            rx_err_oe_n_o <= 1'b1;
            ref_clk_o <= 1'b0;
            ref_clk_oe_n_o <= 1'b1;
            tx_en_o <= 1'b0;
            txd_o <= 2'b00;
            txd1_out_o <= 1'b0;
            txd1_oe_n_o <= 1'b1;
            wake_output_enable_strap_o <= 1'b0;
            wake_event_out_alt_n_o <= 1'b1;
        end else if (ce_i) begin
            ctl_ff <= nxt_ctl;
            ien_ff <= nxt_ien;
            ist_ff <= nxt_ist;
            init_ff <= nxt_init;
            boot_cnt_ff <= nxt_boot_cnt;
            strap_ff <= nxt_strap;
            ref_ff <= nxt_ref;
            mdc_prev_ff <= st_ff[0];
            xi_prev_ff <= {xi_prev_ff[0], crystal_clock_input_i};
            int_pin_ff <= nxt_int_n;
            int_oe_n_ff <= nxt_int_oe_n;
            mdio_o <= mdio_out;
            mdio_oe_n_o <= mdio_oe_n;
            rx_err_o <= rx_err_i; // RQ5
            rx_err_oe_n_o <= ~init_ff; // RQ5
            ref_clk_o <= ref_ff; // RQ1
            ref_clk_oe_n_o <= ctl_ff[`RCSI_CTL_CLK50_BIT]; // RQ2
            tx_en_o <= st_ff[3]; // RQ10
            txd_o <= nand_mode_i ? {1'b0, st_ff[4]} : st_ff[5:4];
            txd1_out_o <= nand_result_i; // RQ11
            txd1_oe_n_o <= ~nand_mode_i; // RQ11
            wake_output_enable_strap_o <= strap_ff;
            wake_event_out_alt_n_o <= ~(wake_alt_sel_i & wake_event_i & strap_ff); // RQ9
        end
    end
    assign interrupt_output_pin_o = int_pin_ff;
    assign interrupt_output_pin_oe_n_o = int_oe_n_ff;
endmodule

// ===== logic/rcsi_params.svh
// Purpose: Offsets, field positions, reset values and timing counts for the pin control block
// Assumes: 100 MHz core clock
// Notes: Register offsets are management register indices
`ifndef RCSI_PARAMS_SVH
`define RCSI_PARAMS_SVH
`define RCSI_REG_INT_CTL_STAT 5'h1b
`define RCSI_REG_PHY_CTL_TWO 5'h1f
`define RCSI_CTL_CLK50_BIT 7
`define RCSI_CTL_INT_POL_BIT 9
`define RCSI_CTL_TWO_RESET 16'h0000
`define RCSI_ICS_RESET 16'h0000
`define RCSI_ICS_EN_LSB 8
`define RCSI_ICS_CAUSES 8
`define RCSI_MDC_TURN_BIT 0
`define RCSI_REFCLK_DIV 1
`define RCSI_STRAP_SETTLE 3'h5
`endif

// ===== logic/rcsi_pkg.sv
// Purpose: Types shared by the pin control block
// Assumes: Nothing
// Notes: Constants live in rcsi_params.svh
package rcsi_pkg;
    typedef enum logic [1:0] {
        RCSI_MS_IDLE,
        RCSI_MS_HDR,
        RCSI_MS_DATA
    } rcsi_mgmt_st_t;
    typedef enum logic {
        RCSI_CLK_25M,
        RCSI_CLK_50M
    } rcsi_clk_mode_t;
endpackage

// ===== logic/rcsi_reg_if.sv
// Purpose: Register access path between the management engine and the pin logic
// Assumes: Single clock domain
// Notes: One write strobe per access
`timescale 1ns/1ps
interface rcsi_reg_if;
    logic wr_stb;
    logic rd_stb;
    logic [4:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    modport eng (output wr_stb, output rd_stb, output addr, output wdata, input rdata);
    modport regs (input wr_stb, input rd_stb, input addr, input wdata, output rdata);
endinterface

// ===== logic/rcsi_mgmt.sv
// Purpose: Serial management slave: clause-22 frames over management clock and data
// Assumes: Management clock and data already synchronised, edges found by caller
// Notes: Any PHY address accepted; read data driven from turnaround second bit
`timescale 1ns/1ps
`include "rcsi_params.svh"
module rcsi_mgmt (
    // Clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    // Sampled management pins
    input wire logic mdc_rise_i,
    input wire logic mdio_in_i,
    // Management data drive, enable active low
    output logic mdio_out_o,
    output logic mdio_oe_n_o,
    // Register access
    rcsi_reg_if.eng reg_port
);
    rcsi_pkg::rcsi_mgmt_st_t st_ff, nxt_st;
    logic [5:0] cnt_ff, nxt_cnt;
    logic [13:0] hdr_ff, nxt_hdr;
    logic [15:0] sh_ff, nxt_sh;
    logic rd_ff, nxt_rd;
    logic [5:0] pre_ff, nxt_pre;
    logic oe_n_ff, nxt_oe_n;
    logic wr_ff, nxt_wr;
    always_comb begin
        nxt_st = st_ff;
        nxt_cnt = cnt_ff;
        nxt_hdr = hdr_ff;
        nxt_sh = sh_ff;
        nxt_rd = rd_ff;
        nxt_pre = pre_ff;
        nxt_oe_n = oe_n_ff;
        nxt_wr = 1'b0;
        if (mdc_rise_i) begin
            unique case (st_ff)
                rcsi_pkg::RCSI_MS_IDLE: begin
                    nxt_oe_n = 1'b1;
                    if (mdio_in_i) begin
                        if (pre_ff != 6'h3f) begin
                            nxt_pre = pre_ff + 6'h01;
                        end
                    end else begin
                        // Start bit 0 after a preamble of ones
                        if (pre_ff >= 6'h1f) begin
                            nxt_st = rcsi_pkg::RCSI_MS_HDR;
                            nxt_cnt = 6'h00;
                        end
                        nxt_pre = 6'h00;
                    end
                end
                rcsi_pkg::RCSI_MS_HDR: begin
                    // Second start bit, op(2), phy(5), reg(5), turnaround first bit
                    nxt_hdr = {hdr_ff[12:0], mdio_in_i};
                    nxt_cnt = cnt_ff + 6'h01;
                    if (cnt_ff == 6'h0d) begin
                        nxt_rd = (hdr_ff[11:10] == 2'b10);
                        nxt_st = rcsi_pkg::RCSI_MS_DATA;
                        nxt_cnt = 6'h00;
                        if (hdr_ff[11:10] == 2'b10) begin
                            nxt_oe_n = 1'b0;
                            nxt_sh = 16'h0000;
                        end else if (hdr_ff[11:10] != 2'b01) begin
                            nxt_st = rcsi_pkg::RCSI_MS_IDLE;
                        end
                    end
                end
                rcsi_pkg::RCSI_MS_DATA: begin
                    nxt_cnt = cnt_ff + 6'h01;
                    if (rd_ff) begin
                        nxt_sh = (cnt_ff == 6'h00) ? reg_port.rdata : {sh_ff[14:0], 1'b0};
                        if (cnt_ff == 6'h10) begin
                            nxt_oe_n = 1'b1;
                            nxt_st = rcsi_pkg::RCSI_MS_IDLE;
                        end
                    end else begin
                        if (cnt_ff != 6'h00) begin
                            nxt_sh = {sh_ff[14:0], mdio_in_i};
                        end
                        if (cnt_ff == 6'h10) begin
                            nxt_wr = 1'b1;
                            nxt_st = rcsi_pkg::RCSI_MS_IDLE;
                        end
                    end
                end
                default: nxt_st = rcsi_pkg::RCSI_MS_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_ff <= rcsi_pkg::RCSI_MS_IDLE;
            cnt_ff <= 6'h00;
            hdr_ff <= 14'h0000;
            sh_ff <= 16'h0000;
            rd_ff <= 1'b0;
            pre_ff <= 6'h00;
            oe_n_ff <= 1'b1;
            wr_ff <= 1'b0;
        end else if (ce_i) begin
            st_ff <= nxt_st;
            cnt_ff <= nxt_cnt;
            hdr_ff <= nxt_hdr;
            sh_ff <= nxt_sh;
            rd_ff <= nxt_rd;
            pre_ff <= nxt_pre;
            oe_n_ff <= nxt_oe_n;
            wr_ff <= nxt_wr;
        end
    end

    assign reg_port.wr_stb = wr_ff;
    // Read strobe on the very edge that loads the shifter, so clear-on-read loses no cause
    assign reg_port.rd_stb = mdc_rise_i & rd_ff & (st_ff == rcsi_pkg::RCSI_MS_DATA) &
        (cnt_ff == 6'h00);
    assign reg_port.addr = hdr_ff[5:1];
    assign reg_port.wdata = sh_ff;
    assign mdio_out_o = (cnt_ff == 6'h00) ? 1'b0 : sh_ff[15];
    assign mdio_oe_n_o = oe_n_ff;
endmodule

// ===== sim/rcsi_monitor.sv
// Purpose: Port checks for the pin control block
// Assumes: ce_i held high by the bench
// Notes: Bound into rcsi_top
`timescale 1ns/1ps
module rcsi_monitor (
    // Clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // Watched pins
    input wire logic rx_err_i,
    input wire logic rx_err_pin_i,
    input wire logic rx_err_o,
    input wire logic rx_err_oe_n_o,
    input wire logic ref_clk_o,
    input wire logic ref_clk_oe_n_o,
    input wire logic wake_event_i,
    input wire logic wake_alt_sel_i,
    input wire logic nand_mode_i,
    input wire logic nand_result_i,
    input wire logic txd1_out_o,
    input wire logic txd1_oe_n_o,
    input wire logic [1:0] txd_o,
    input wire logic tx_en_i,
    input wire logic [1:0] txd_i,
    input wire logic tx_en_o,
    input wire logic wake_output_enable_strap_o,
    input wire logic wake_event_out_alt_n_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    refclk_toggle_a: assert property (!ref_clk_oe_n_o && !$past(ref_clk_oe_n_o)
        |-> ref_clk_o != $past(ref_clk_o)) else $error("reference clock stalled");
    refclk_idle_a: assert property (ref_clk_oe_n_o && $past(ref_clk_oe_n_o)
        |-> !ref_clk_o) else $error("reference clock runs while unused");
    rxerr_follow_a: assert property ((rx_err_i == $past(rx_err_i))[*3] ##0 !rx_err_oe_n_o
        |-> rx_err_o == rx_err_i) else $error("receive error not passed on");
    rxerr_drive_a: assert property (!rx_err_oe_n_o |=> !rx_err_oe_n_o)
        else $error("receive error pin released");
    strap_latch_a: assert property ($rose(!rx_err_oe_n_o)
        |-> wake_output_enable_strap_o == rx_err_pin_i) else $error("strap not latched");
    strap_hold_a: assert property (!rx_err_oe_n_o && !$past(rx_err_oe_n_o)
        |-> $stable(wake_output_enable_strap_o)) else $error("strap changed in run");
    wake_alt_a: assert property ((wake_alt_sel_i && wake_event_i && wake_output_enable_strap_o)[*4]
        |-> !wake_event_out_alt_n_o) else $error("wake event not shown");
    wake_strap_a: assert property (!wake_output_enable_strap_o |-> wake_event_out_alt_n_o)
        else $error("wake output without strap");
    nand_drive_a: assert property (nand_mode_i[*3] |-> !txd1_oe_n_o && !txd_o[1])
        else $error("test output not driven");
    nand_off_a: assert property ((!nand_mode_i)[*3] |-> txd1_oe_n_o)
        else $error("test output driven outside test");
    nand_value_a: assert property ((nand_mode_i && nand_result_i == $past(nand_result_i))[*3]
        |-> txd1_out_o == nand_result_i) else $error("test output wrong");
    tx_follow_a: assert property ((resetn_i && !nand_mode_i && $stable(txd_i) && $stable(tx_en_i))[*6]
        |-> txd_o == txd_i && tx_en_o == tx_en_i) else $error("transmit pins not passed on");
endmodule
bind rcsi_top rcsi_monitor rcsi_monitor_inst (.clk_i, .resetn_i, .rx_err_i, .rx_err_pin_i,
    .rx_err_o, .rx_err_oe_n_o, .ref_clk_o, .ref_clk_oe_n_o, .wake_event_i, .wake_alt_sel_i,
    .nand_mode_i, .nand_result_i, .txd1_out_o, .txd1_oe_n_o, .txd_o, .tx_en_i, .txd_i, .tx_en_o,
    .wake_output_enable_strap_o, .wake_event_out_alt_n_o);

// ===== sim/rcsi_mac_model.sv
// Purpose: MAC side of the transmit pins
// Assumes: Bench clock
// Notes: Random frame data while sending
`timescale 1ns/1ps
module rcsi_mac_model (
    // Clock and control
    input wire logic clk_i,
    input wire logic send_i,
    // Transmit pins
    output logic tx_en_o,
    output logic [1:0] txd_o
);
    integer seed = 32'hdbba6234;
    // Each dibit is held for eight core clocks so the pin sampler passes it
    logic [2:0] hold_cnt = 3'h0;
    initial begin
        tx_en_o = 1'b0;
        txd_o = 2'h0;
    end
    always @(posedge clk_i) begin
        hold_cnt <= hold_cnt + 3'h1;
        if (hold_cnt == 3'h0) begin
            tx_en_o <= send_i;
            txd_o <= send_i ? 2'($random(seed)) : 2'h0;
        end
    end
endmodule

// ===== sim/rcsi_top_tb_top.sv
// Purpose: Self-checking bench for the pin control block
// Assumes: Management clock of 170 ns made by the bench
// Notes: Registers reached only over management frames
`timescale 1ns/1ps
`include "rcsi_params.svh"
module rcsi_top_tb_top;
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic mdc_i = 1'b0;
    logic mdio_drv = 1'b1;
    logic rx_err_i = 1'b0;
    logic rx_err_pin_i = 1'b1;
    logic xtal = 1'b0;
    logic [7:0] int_cause_i = 8'h00;
    logic wake_event_i = 1'b0;
    logic wake_alt_sel_i = 1'b0;
    logic nand_mode_i = 1'b0;
    logic nand_result_i = 1'b0;
    logic send = 1'b0;
    logic tx_en_i, mdio_o, mdio_oe_n_o, rx_err_o, rx_err_oe_n_o, ref_clk_o, ref_clk_oe_n_o;
    logic interrupt_output_pin_o, interrupt_output_pin_oe_n_o, tx_en_o, txd1_out_o, txd1_oe_n_o;
    logic wake_output_enable_strap_o, wake_event_out_alt_n_o;
    logic [1:0] txd_i, txd_o;
    logic [15:0] q;
    logic [7:0] en, cb;
    integer seed = 32'hdbba6234;
    integer miscompares = 0;
    integer check_count = 0;
    // Pulled-up open-drain wires
    wire mdio_i = mdio_drv & (mdio_oe_n_o | mdio_o);
    wire int_w = interrupt_output_pin_oe_n_o | interrupt_output_pin_o;
    rcsi_top rcsi_top_inst (.clk_i, .resetn_i, .ce_i(1'b1), .crystal_clock_input_i(xtal),
        .mdc_i, .mdio_i, .mdio_o, .mdio_oe_n_o, .rx_err_i, .rx_err_pin_i, .rx_err_o,
        .rx_err_oe_n_o, .ref_clk_o, .ref_clk_oe_n_o, .int_cause_i, .wake_event_i,
        .wake_alt_sel_i, .interrupt_output_pin_o, .interrupt_output_pin_oe_n_o, .tx_en_i,
        .txd_i, .tx_en_o, .txd_o, .nand_mode_i, .nand_result_i, .txd1_out_o, .txd1_oe_n_o,
        .wake_output_enable_strap_o, .wake_event_out_alt_n_o);
    rcsi_mac_model rcsi_mac_model_inst (.clk_i, .send_i(send), .tx_en_o(tx_en_i), .txd_o(txd_i));
    function logic ipin(input logic pol, input logic act);
        return pol ? act : ~act;
    endfunction
    function logic [15:0] ics(input logic [7:0] e, input logic [7:0] s);
        return {e, s};
    endfunction
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count = check_count + 1;
        if (seen !== exp) begin
            miscompares = miscompares + 1;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task stop_test;
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // One management bit; reply sampled just before the clock rises
    task mbit(input logic b, output logic s);
        @(posedge clk_i);
        mdc_i <= 1'b0;
        mdio_drv <= b;
        repeat (8) @(posedge clk_i);
        #1;
        s = mdio_i;
        mdc_i <= 1'b1;
        repeat (8) @(posedge clk_i);
    endtask
    task mgmt(input logic rd, input logic [4:0] ra, input logic [15:0] wd);
        logic [63:0] f;
        logic s;
        f = {32'hffffffff, 2'b01, rd, ~rd, 5'h00, ra, rd ? 2'b11 : 2'b10, rd ? 16'hffff : wd};
        for (int i = 63; i >= 0; i--) begin
            mbit(f[i], s);
            if (i < 16)
                q[i] = s;
        end
        repeat (4) @(posedge clk_i);
        #1;
    endtask
    task rdc(input logic [4:0] a, input logic [15:0] e);
        mgmt(1'b1, a, 16'h0000);
        chk(q, e);
    endtask
    initial forever #5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        xtal <= ~xtal;
        if ($random(seed) % 8 == 0)
            rx_err_i <= ~rx_err_i;
    end
    initial begin
        #300000;
        miscompares = miscompares + 1;
        stop_test;
    end
    initial begin
        repeat (8) @(posedge clk_i);
        resetn_i <= 1'b1;
        send <= 1'b1;
        repeat (10) @(posedge clk_i);
        #1;
        chk(ref_clk_oe_n_o, 1'b0);
        chk(wake_output_enable_strap_o, 1'b1);
        rdc(`RCSI_REG_PHY_CTL_TWO, `RCSI_CTL_TWO_RESET);
        mgmt(1'b0, `RCSI_REG_PHY_CTL_TWO, 16'h0080);
        rdc(`RCSI_REG_PHY_CTL_TWO, 16'h0080);
        chk(ref_clk_oe_n_o, 1'b1);
        mgmt(1'b0, 5'h05, 16'hffff);
        rdc(5'h05, 16'h0000);
        for (int p = 0; p < 2; p++) begin
            mgmt(1'b0, `RCSI_REG_PHY_CTL_TWO, p ? 16'h0200 : 16'h0000);
            chk(ref_clk_oe_n_o, 1'b0);
            en = 8'($random(seed)) | 8'h01;
            cb = en & (~en + 8'h01);
            mgmt(1'b0, `RCSI_REG_INT_CTL_STAT, {en, 8'h00});
            chk(int_w, ipin(p[0], 1'b0));
            @(posedge clk_i);
            int_cause_i <= cb;
            @(posedge clk_i);
            int_cause_i <= 8'h00;
            repeat (6) @(posedge clk_i);
            #1;
            chk(int_w, ipin(p[0], 1'b1));
            rdc(`RCSI_REG_INT_CTL_STAT, ics(en, cb));
            chk(int_w, ipin(p[0], 1'b0));
        end
        mgmt(1'b0, `RCSI_REG_PHY_CTL_TWO, 16'h0000);
        wake_alt_sel_i <= 1'b1;
        wake_event_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        #1;
        chk(wake_event_out_alt_n_o, 1'b0);
        chk(int_w, 1'b0);
        @(posedge clk_i);
        nand_mode_i <= 1'b1;
        for (int k = 0; k < 6; k++) begin
            @(posedge clk_i);
            nand_result_i <= 1'($random(seed));
            repeat (5) @(posedge clk_i);
            #1;
            chk({txd1_oe_n_o, txd1_out_o}, {1'b0, nand_result_i});
        end
        @(posedge clk_i);
        nand_mode_i <= 1'b0;
        rx_err_pin_i <= 1'b0;
        resetn_i <= 1'b0;
        repeat (8) @(posedge clk_i);
        resetn_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        #1;
        chk(wake_output_enable_strap_o, 1'b0);
        chk(wake_event_out_alt_n_o, 1'b1);
        rdc(`RCSI_REG_PHY_CTL_TWO, `RCSI_CTL_TWO_RESET);
        stop_test;
    end
endmodule
